/* File: card_status_pkg.sv */
// card_status_pkg: offsets, field positions and codes of the low status half
// assumes: a 32-bit register port with byte offsets and 16-bit status words
package card_status_pkg;

   // ------------------------------------------------------------------
   // register port
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_LIVE_OFF = 8'h00;
   localparam logic [7:0] REG_EVENT_OFF = 8'h04;
   localparam logic [7:0] REG_STATE_OFF = 8'h08;
   localparam logic [7:0] REG_RESP_OFF = 8'h0C;
   localparam logic [31:0] REG_UNMAPPED_VAL = 32'h0000_0000;

   // ------------------------------------------------------------------
   // status field positions
   // ------------------------------------------------------------------
   localparam int STS_W = 16;
   localparam int BIT_ERASE_SKIP = 15;
   localparam int BIT_ECC_BYPASS = 14;
   localparam int BIT_ERASE_ABORT = 13;
   localparam int STATE_MSB = 12;
   localparam int STATE_LSB = 9;
   localparam int BIT_READY = 8;
   localparam int BIT_EXT_EVENT = 6;
   localparam int BIT_APP = 5;
   localparam int BIT_AUTH = 3;
   localparam logic [15:0] LATCHED_MASK = 16'hA028;
   localparam logic [15:0] RESERVED_MASK = 16'h0097;
   localparam int RESP_BUSY_BIT = 16;
   localparam int RESP_IDX_LSB = 17;

   // ------------------------------------------------------------------
   // state codes and commands
   // ------------------------------------------------------------------
   localparam logic [3:0] ST_IDLE = 4'h0;
   localparam logic [3:0] ST_DIS = 4'h8;
   localparam logic [3:0] ST_IO_RSVD = 4'hF;
   localparam logic [3:0] STATE_RESET = 4'h0;
   localparam logic [5:0] CMD_APP_PREFIX = 6'h37;
   localparam int CMD_IDX_W = 6;
   localparam logic [4:0] SHIFT_COUNT = 5'h10;

endpackage

/* File: status_shifter.sv */
// status_shifter: sends a 16-bit status word msb first, one bit per tick
// assumes: ticks come from link clock edges found on the local clock
`timescale 1ns/10ps

module status_shifter (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // word to send
   input wire logic load_i,
   input wire logic [15:0] data_i,
   input wire logic bit_tick_i,
   // serial side
   output logic bit_o,
   output logic busy_o,
   output logic done_o
);

   logic [15:0] shift_r;
   logic [4:0] left_r;
   logic done_r;
   wire last_tick = bit_tick_i && (left_r == 5'h01);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_r <= 16'h0000;
         left_r <= 5'h00;
         done_r <= 1'b0;
      end else if (load_i) begin
         shift_r <= data_i;
         left_r <= card_status_pkg::SHIFT_COUNT;
         done_r <= 1'b0;
      end else if (bit_tick_i && (left_r != 5'h00)) begin
         shift_r <= {shift_r[14:0], 1'b0};
         left_r <= left_r - 5'h01;
         done_r <= last_tick;
      end else begin
         done_r <= 1'b0;
      end
   end

   assign bit_o = shift_r[15];
   assign busy_o = (left_r != 5'h00);
   assign done_o = done_r;

endmodule

/* File: card_status_low_half.sv */
// card_status_low_half: lower half of the card status word and its delivery
// assumes: command decoder and card logic on clk_i, link clock from a pin
`timescale 1ns/10ps

// Summary of operation
// - bit 15 latches when an erase skipped protected blocks or erased a protected card.
// - bit 14 is one while commands run without the internal error correction.
// - bit 13 latches when a pending erase sequence is dropped by a foreign command.
// - bits 12:9 carry the state code caught when the command arrived.
// - a state change made by a command shows only in the next command's response.
// - bit 8 follows the buffer-empty and ready indication given on the bus.
// - bit 6 is set by extension functions while an event waits, else zero.
// - bit 5 is set from the app prefix command's arrival until a response carrying it is delivered.
// - bit 3 latches when the key exchange commands come out of order.
// - bits 7, 4, 2, 1 and 0 are reserved positions.
// - the state field never shows pre-initialisation or boot states.
// - a response carries only the bits that its command may affect.
// - the state field is tied to the previous command and renewed on each valid one.
// - bits 14, 8 and 6 track the present condition and do not latch.
// - unused reserved bits read zero in every response.
module card_status_low_half (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // command decoder
   input wire logic cmd_valid_i,
   input wire logic [5:0] cmd_index_i,
   // card condition
   input wire logic erase_skip_i,
   input wire logic erase_abort_i,
   input wire logic auth_fault_i,
   input wire logic ecc_bypass_i,
   input wire logic buf_empty_i,
   input wire logic extension_event_flag_i,
   // link
   input wire logic link_clk_i,
   output logic resp_bit_o,
   output logic resp_busy_o,
   output logic resp_done_o
);

   // ------------------------------------------------------------------
   // reset release and link clock sampling
   // ------------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic lclk_meta_r;
   logic lclk_sync_r;
   logic lclk_prev_r;
   logic link_rise;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         lclk_meta_r <= 1'b0;
         lclk_sync_r <= 1'b0;
         lclk_prev_r <= 1'b0;
      end else begin
         lclk_meta_r <= link_clk_i;
         lclk_sync_r <= lclk_meta_r;
         lclk_prev_r <= lclk_sync_r;
      end
   end
   assign link_rise = lclk_sync_r && !lclk_prev_r;

   // ------------------------------------------------------------------
   // bits each command may affect
   // ------------------------------------------------------------------
   function automatic logic [15:0] cmd_mask(input logic [5:0] idx, input logic app);
      logic [15:0] m;
      m = 16'h1E00;
      case (idx)
         6'd6, 6'd12: m = m | 16'h4040;
         6'd7, 6'd13, 6'd20, 6'd24, 6'd25: m = m | 16'hE140;
         6'd16, 6'd17, 6'd18, 6'd19, 6'd22, 6'd23, 6'd26, 6'd27, 6'd32: m = m | 16'hE040;
         6'd28, 6'd29, 6'd30: m = m | 16'hE000;
         default: m = m;
      endcase
      if ((idx == card_status_pkg::CMD_APP_PREFIX) || app) begin
         m = m | 16'h0028;
      end
      return m & ~card_status_pkg::RESERVED_MASK;
   endfunction

   function automatic logic state_code_ok(input logic [3:0] code);
      return (code <= card_status_pkg::ST_DIS) || (code == card_status_pkg::ST_IO_RSVD);
   endfunction

   // ------------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------------
   wire hit_live = (reg_addr_i == card_status_pkg::REG_LIVE_OFF);
   wire hit_event = (reg_addr_i == card_status_pkg::REG_EVENT_OFF);
   wire hit_state = (reg_addr_i == card_status_pkg::REG_STATE_OFF);
   wire hit_resp = (reg_addr_i == card_status_pkg::REG_RESP_OFF);
   wire event_wr = reg_wr_i && hit_event;
   wire state_wr = reg_wr_i && hit_state;
   wire [3:0] state_wdata = reg_wdata_i[3:0];

   // ------------------------------------------------------------------
   // latched flags, set wins over clear
   // ------------------------------------------------------------------
   logic skip_r;
   logic skip_nxt;
   logic abort_r;
   logic abort_nxt;
   logic auth_r;
   logic auth_nxt;
   logic app_r;
   logic app_nxt;
   logic [3:0] state_r;
   logic [3:0] state_nxt;
   logic shift_done;
   logic [15:0] sent_r;

   wire skip_set = erase_skip_i || (event_wr && reg_wdata_i[card_status_pkg::BIT_ERASE_SKIP]);
   wire abort_set = erase_abort_i || (event_wr && reg_wdata_i[card_status_pkg::BIT_ERASE_ABORT]);
   wire auth_set = auth_fault_i || (event_wr && reg_wdata_i[card_status_pkg::BIT_AUTH]);
   wire app_set = (cmd_valid_i && (cmd_index_i == card_status_pkg::CMD_APP_PREFIX))
      || (event_wr && reg_wdata_i[card_status_pkg::BIT_APP]);
   wire skip_clr = shift_done && sent_r[card_status_pkg::BIT_ERASE_SKIP];
   wire abort_clr = shift_done && sent_r[card_status_pkg::BIT_ERASE_ABORT];
   wire auth_clr = shift_done && sent_r[card_status_pkg::BIT_AUTH];
   wire app_clr = shift_done && sent_r[card_status_pkg::BIT_APP];

   assign skip_nxt = skip_set || (skip_r && !skip_clr);
   assign abort_nxt = abort_set || (abort_r && !abort_clr);
   assign auth_nxt = auth_set || (auth_r && !auth_clr);
   assign app_nxt = app_set || (app_r && !app_clr);
   // codes 9 to 14 are refused and the old state stays; code 15 is taken
   assign state_nxt = (state_wr && state_code_ok(state_wdata)) ? state_wdata : state_r;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         skip_r <= 1'b0;
         abort_r <= 1'b0;
         auth_r <= 1'b0;
         app_r <= 1'b0;
         state_r <= card_status_pkg::STATE_RESET;
      end else begin
         skip_r <= skip_nxt;
         abort_r <= abort_nxt;
         auth_r <= auth_nxt;
         app_r <= app_nxt;
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------------
   // live status word
   // ------------------------------------------------------------------
   logic [15:0] live_word;
   always_comb begin
      live_word = 16'h0000;
      live_word[card_status_pkg::BIT_ERASE_SKIP] = skip_r;
      live_word[card_status_pkg::BIT_ECC_BYPASS] = ecc_bypass_i;
      live_word[card_status_pkg::BIT_ERASE_ABORT] = abort_r;
      live_word[card_status_pkg::STATE_MSB:card_status_pkg::STATE_LSB] = state_r;
      live_word[card_status_pkg::BIT_READY] = buf_empty_i;
      live_word[card_status_pkg::BIT_EXT_EVENT] = extension_event_flag_i;
      live_word[card_status_pkg::BIT_APP] = app_r || app_set;
      live_word[card_status_pkg::BIT_AUTH] = auth_r;
   end

   // ------------------------------------------------------------------
   // response capture and delivery
   // ------------------------------------------------------------------
   typedef enum logic {RESP_IDLE, RESP_SEND} resp_st_t;
   resp_st_t resp_st_r;
   resp_st_t resp_st_nxt;
   logic [15:0] resp_r;
   logic [5:0] last_idx_r;
   logic shift_busy;
   logic shift_bit;

   // state is caught at arrival; a later state write waits for the next command
   wire [15:0] cur_mask = cmd_mask(cmd_index_i, app_r);
   wire [15:0] resp_nxt = live_word & cur_mask;

   always_comb begin
      case (resp_st_r)
         RESP_IDLE: resp_st_nxt = cmd_valid_i ? RESP_SEND : RESP_IDLE;
         RESP_SEND: resp_st_nxt = (shift_done && !cmd_valid_i) ? RESP_IDLE : RESP_SEND;
         default: resp_st_nxt = RESP_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         resp_st_r <= RESP_IDLE;
         resp_r <= 16'h0000;
         sent_r <= 16'h0000;
         last_idx_r <= 6'h00;
      end else begin
         resp_st_r <= resp_st_nxt;
         if (cmd_valid_i) begin
            resp_r <= resp_nxt;
            sent_r <= resp_nxt & card_status_pkg::LATCHED_MASK;
            last_idx_r <= cmd_index_i;
         end
      end
   end

   status_shifter u_shifter (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .load_i(cmd_valid_i),
      .data_i(resp_nxt),
      .bit_tick_i(link_rise),
      .bit_o(shift_bit),
      .busy_o(shift_busy),
      .done_o(shift_done)
   );

   assign resp_bit_o = shift_bit;
   assign resp_busy_o = shift_busy;
   assign resp_done_o = shift_done;

   // ------------------------------------------------------------------
   // register read
   // ------------------------------------------------------------------
   logic [31:0] rd_mux;
   assign rd_mux = hit_live ? {16'h0000, live_word} :
      hit_state ? {28'h000_0000, state_r} :
      hit_resp ? {9'h000, last_idx_r, shift_busy, resp_r} :
      card_status_pkg::REG_UNMAPPED_VAL;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_mux;
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   sequence s_cmd_arrives;
      cmd_valid_i;
   endsequence

   sequence s_quiet_next;
      !cmd_valid_i;
   endsequence

   AST_RESERVED_ZERO: assert property (
      (resp_r & card_status_pkg::RESERVED_MASK) == 16'h0000)
      else $error("reserved status bit set in response");

   AST_STATE_CAPTURE: assert property (
      s_cmd_arrives |=> resp_r[12:9] == $past(state_r))
      else $error("state field not caught at command arrival");

   AST_STATE_NEXT_CMD: assert property (
      s_cmd_arrives ##1 s_quiet_next |=> $stable(resp_r[12:9]))
      else $error("state change leaked into current response");

   AST_MASKED: assert property (
      (resp_r & ~cmd_mask(last_idx_r, 1'b1)) == 16'h0000)
      else $error("response bit outside allowed set");

   AST_READY_TRACK: assert property (
      s_cmd_arrives ##0 (cur_mask[8] == 1'b1)
      |=> resp_r[8] == $past(buf_empty_i))
      else $error("ready bit does not follow buffer empty");

   AST_APP_SET: assert property (
      cmd_valid_i && (cmd_index_i == card_status_pkg::CMD_APP_PREFIX) |=> app_r)
      else $error("app command expectation not set");

   AST_SKIP_SET: assert property (
      erase_skip_i |=> skip_r)
      else $error("erase skip flag lost");

   AST_ABORT_SET: assert property (
      erase_abort_i |=> abort_r)
      else $error("erase abort flag lost");

   AST_AUTH_SET: assert property (
      auth_fault_i |=> auth_r)
      else $error("auth sequence flag lost");

   AST_CLEAR_SENT: assert property (
      shift_done && sent_r[15] && !skip_set |=> !skip_r)
      else $error("delivered erase skip flag not cleared");

   AST_STATE_LEGAL: assert property (
      state_r <= card_status_pkg::ST_DIS || state_r == card_status_pkg::ST_IO_RSVD)
      else $error("unreported state code held");

   AST_ECC_TRACK: assert property (
      s_cmd_arrives ##0 cur_mask[14] |=> resp_r[14] == $past(ecc_bypass_i))
      else $error("ecc bypass bit wrong in response");

   AST_EVENT_TRACK: assert property (
      s_cmd_arrives ##0 !extension_event_flag_i |=> !resp_r[6])
      else $error("extension event bit set without event");

   AST_DELIVER_BOUND: assert property (
      s_cmd_arrives |=> ##[0:700] (shift_done || cmd_valid_i))
      else $error("response not delivered in time");

   AST_IDLE_QUIET: assert property (
      resp_st_r == RESP_IDLE |-> !shift_busy)
      else $error("shifter busy with no response pending");

   AST_ABORT_CLEAR: assert property (
      shift_done && sent_r[13] && !abort_set |=> !abort_r)
      else $error("delivered erase abort flag not cleared");

   AST_AUTH_CLEAR: assert property (
      shift_done && sent_r[3] && !auth_set |=> !auth_r)
      else $error("delivered auth sequence flag not cleared");

   AST_APP_CLEAR: assert property (
      shift_done && sent_r[5] && !app_set |=> !app_r)
      else $error("delivered app command flag not cleared");

   AST_SKIP_HOLD: assert property (
      skip_r && !skip_clr |=> skip_r)
      else $error("erase skip flag dropped before delivery");

   AST_STATE_REFUSED: assert property (
      state_wr && !state_code_ok(state_wdata) |=> $stable(state_r))
      else $error("unreported state code accepted");

endmodule

/* File: host_model.sv */
// host_model: host side that issues commands and clocks in the status bits
// assumes: design samples link_clk_o on clk_i and answers msb first
`timescale 1ns/10ps

module host_model (
   // clock
   input wire logic clk_i,
   // command side
   output logic cmd_valid_o,
   output logic [5:0] cmd_index_o,
   // link side
   output logic link_clk_o,
   input wire logic resp_bit_i,
   input wire logic resp_done_i
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_index_o = 6'h00;
      link_clk_o = 1'b0;
   end

   // the done pulse ends before the last link fall, so it is counted here
   int done_cnt = 0;

   always @(posedge clk_i) begin
      if (resp_done_i === 1'b1) begin
         done_cnt <= done_cnt + 1;
      end
   end

   // ------------------------------------------------------------------
   // one command and its 16-bit status frame
   // ------------------------------------------------------------------
   task automatic run_cmd(input logic [5:0] idx, output logic [15:0] word, output logic ok);
      int cnt0;
      ok = 1'b0;
      word = 16'h0000;
      cnt0 = done_cnt;
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_index_o <= idx;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      // link clock runs only inside the frame, off the local clock phase
      #3;
      for (int i = 0; i < 16; i++) begin
         #16 link_clk_o = 1'b1;
         word = {word[14:0], resp_bit_i};
         #16 link_clk_o = 1'b0;
      end
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_i);
         #1;
         if (done_cnt != cnt0) begin
            ok = 1'b1;
            break;
         end
      end
   endtask
endmodule

/* File: tb_top.sv */
// tb_top: register and command tests of the low status half
// assumes: host_model clocks the link; registers answer one cycle after a read
`timescale 1ns/10ps

module tb_top;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic cmd_valid_i;
   logic [5:0] cmd_index_i;
   logic erase_skip_i = 1'b0;
   logic erase_abort_i = 1'b0;
   logic auth_fault_i = 1'b0;
   logic ecc_bypass_i = 1'b0;
   logic buf_empty_i = 1'b0;
   logic extension_event_flag_i = 1'b0;
   logic link_clk_i;
   logic resp_bit_o;
   logic resp_busy_o;
   logic resp_done_o;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] d;
   logic [15:0] w;
   logic ok;

   always #2 clk_i = ~clk_i;

   card_status_low_half u_card_status_low_half (
      .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .cmd_valid_i(cmd_valid_i), .cmd_index_i(cmd_index_i), .erase_skip_i(erase_skip_i),
      .erase_abort_i(erase_abort_i), .auth_fault_i(auth_fault_i),
      .ecc_bypass_i(ecc_bypass_i), .buf_empty_i(buf_empty_i),
      .extension_event_flag_i(extension_event_flag_i), .link_clk_i(link_clk_i),
      .resp_bit_o(resp_bit_o), .resp_busy_o(resp_busy_o), .resp_done_o(resp_done_o)
   );

   host_model u_host_model (
      .clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_index_o(cmd_index_i),
      .link_clk_o(link_clk_i), .resp_bit_i(resp_bit_o), .resp_done_i(resp_done_o)
   );

   // ------------------------------------------------------------------
   // access and check tasks
   // ------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      v = reg_rdata_o;
   endtask

   task automatic pulse(input logic [2:0] m);
      @(posedge clk_i);
      {erase_skip_i, erase_abort_i, auth_fault_i} <= m;
      @(posedge clk_i);
      {erase_skip_i, erase_abort_i, auth_fault_i} <= 3'b000;
   endtask

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic cmd(input logic [5:0] idx, input logic [15:0] e);
      u_host_model.run_cmd(idx, w, ok);
      chk("done", 32'h0000_0001, {31'h0000_0000, ok});
      chk("resp", {16'h0000, e}, {16'h0000, w});
      repeat (2) @(posedge clk_i);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end

   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("live", 32'h0000_0000, d);
      rd(8'h10, d);
      chk("unmapped", card_status_pkg::REG_UNMAPPED_VAL, d);
      wr(card_status_pkg::REG_LIVE_OFF, 32'h0000_FFFF);
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("live ro", 32'h0000_0000, d);
      for (int i = 0; i < 9; i++) begin
         wr(card_status_pkg::REG_STATE_OFF, 32'(i));
         rd(card_status_pkg::REG_STATE_OFF, d);
         chk("state", 32'(i), d);
      end
      wr(card_status_pkg::REG_STATE_OFF, 32'h0000_000A);
      rd(card_status_pkg::REG_STATE_OFF, d);
      chk("state rsvd", 32'h0000_0008, d);
      wr(card_status_pkg::REG_STATE_OFF, 32'h0000_0004);
      ecc_bypass_i <= 1'b1;
      buf_empty_i <= 1'b1;
      extension_event_flag_i <= 1'b1;
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("live lvl", 32'h0000_4940, d);
      ecc_bypass_i <= 1'b0;
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("live ecc", 32'h0000_0940, d);
      pulse(3'b100);
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("live skip", 32'h0000_8940, d);
      cmd(6'd3, 16'h0800);
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("kept", 32'h0000_8940, d);
      fork
         cmd(6'd13, 16'h8940);
         begin
            repeat (3) @(posedge clk_i);
            wr(card_status_pkg::REG_STATE_OFF, 32'h0000_0007);
            #1;
            chk("busy", 32'h0000_0001, {31'h0000_0000, resp_busy_o});
         end
      join
      rd(card_status_pkg::REG_RESP_OFF, d);
      chk("resp reg", 32'h001A_8940, d);
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("cleared", 32'h0000_0F40, d);
      cmd(6'd13, 16'h0F40);
      ecc_bypass_i <= 1'b1;
      pulse(3'b010);
      cmd(6'd7, 16'h6F40);
      wr(card_status_pkg::REG_EVENT_OFF, 32'h0000_2008);
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("event set", 32'h0000_6F48, d);
      ecc_bypass_i <= 1'b0;
      buf_empty_i <= 1'b0;
      extension_event_flag_i <= 1'b0;
      pulse(3'b001);
      cmd(card_status_pkg::CMD_APP_PREFIX, 16'h0E28);
      rd(card_status_pkg::REG_LIVE_OFF, d);
      chk("app clr", 32'h0000_2E00, d);
      conclude();
   end
endmodule
